// ---- rtl/bspm_power_manager.sv ----
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "bspm_map.svh"
module bspm_power_manager (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sleep handshake with the blocks.
  bspm_sleep_if.pm sif,
  // Processor and interrupt side, same clock.
  input wire logic cpu_sleep,
  input wire logic cpu_irq_taken,
  input wire logic wake_irq,
  input wire logic espi_irq,
  // Asynchronous pins and events.
  input wire logic pll_lock,
  input wire logic dbg_access,
  input wire logic [`BSPM_WO_W-1:0] wake_only_event_group,
  input wire logic espi_cs_n,
  // Clock controls.
  output logic dom_clk_en,
  output logic pll_en,
  output logic ring_osc_en,
  output logic espi_clk_en,
  output logic nonwake_irq_en,
  output logic test_clock_output
);

  // Synchroniser stages.
  logic [`BSPM_NB-1:0] dem_m, dem_s;
  logic [`BSPM_WO_W-1:0] wo_m, wo_s;
  logic lock_m, lock_s, dbg_m, dbg_s, cs_m, cs_s, cs_d;

  // Registers and state.
  logic heavy, sleep_all, early;
  logic [`BSPM_NB-1:0] sleep_en;
  logic [`BSPM_WO_W-1:0] wo_en;
  bspm_pkg::bspm_state_t state, next_state;
  logic [2:0] blank_cnt, settle_cnt;
  logic slept_heavy;

  // Decoded conditions.
  logic cmd_sleep, enter_ok, cs_fall, wo_hit, espi_hit, wr, rd, dom_on;

  // Two-flop synchronisers for every asynchronous input.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dem_m <= '0;
      dem_s <= '0;
      wo_m <= '0;
      wo_s <= '0;
      lock_m <= 1'b0;
      lock_s <= 1'b0;
      dbg_m <= 1'b0;
      dbg_s <= 1'b0;
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
    end else begin
      dem_m <= sif.clk_demand;
      dem_s <= dem_m;
      wo_m <= wake_only_event_group;
      wo_s <= wo_m;
      lock_m <= pll_lock;
      lock_s <= lock_m;
      dbg_m <= dbg_access;
      dbg_s <= dbg_m;
      cs_m <= espi_cs_n;
      cs_s <= cs_m;
      cs_d <= cs_s;
    end
  end

  // Entry, wake-only and chip-select decodes.
  assign cmd_sleep = sleep_all | (&sleep_en);
  assign enter_ok = cmd_sleep & ~(|dem_s) & cpu_sleep & (lock_s | (early & heavy));
  assign cs_fall = cs_d & ~cs_s;
  assign espi_hit = wo_en[`BSPM_WO_ESPI_BIT] & cs_fall;
  assign wo_hit = |(wo_s & wo_en);
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;

  // Power state sequencing.
  always_comb begin
    next_state = state;
    unique case (state)
      bspm_pkg::BSPM_RUN: begin
        if (enter_ok) begin
          next_state = bspm_pkg::BSPM_SLEEP;
        end
      end
      bspm_pkg::BSPM_SLEEP: begin
        if (wake_irq) begin
          next_state = bspm_pkg::BSPM_RUN;
        end else if (dbg_s) begin
          next_state = bspm_pkg::BSPM_PSEUDO;
        end else if (espi_hit) begin
          next_state = bspm_pkg::BSPM_ESPI;
        end else if (wo_hit) begin
          next_state = bspm_pkg::BSPM_WONLY;
        end
      end
      bspm_pkg::BSPM_PSEUDO: begin
        if (wake_irq) begin
          next_state = bspm_pkg::BSPM_RUN;
        end else if (!dbg_s) begin
          next_state = bspm_pkg::BSPM_SLEEP;
        end
      end
      bspm_pkg::BSPM_WONLY: begin
        if (wake_irq) begin
          next_state = bspm_pkg::BSPM_RUN;
        end else if (settle_cnt == `BSPM_WO_SETTLE_CYC) begin
          next_state = bspm_pkg::BSPM_SLEEP;
        end
      end
      bspm_pkg::BSPM_ESPI: begin
        if (wake_irq || espi_irq) begin
          next_state = bspm_pkg::BSPM_RUN;
        end else if (cs_s) begin
          next_state = bspm_pkg::BSPM_SLEEP;
        end
      end
      default: next_state = bspm_pkg::BSPM_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= bspm_pkg::BSPM_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Wake-only settle: counts quiet cycles with no demand from any block.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= 3'h0;
    end else if (state != bspm_pkg::BSPM_WONLY || (|dem_s)) begin
      settle_cnt <= 3'h0;
    end else if (settle_cnt != `BSPM_WO_SETTLE_CYC) begin
      settle_cnt <= settle_cnt + 3'h1;
    end
  end

  // Brief blanking of all sleep requests on a real wake.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_cnt <= 3'h0;
    end else if (next_state == bspm_pkg::BSPM_RUN && state != bspm_pkg::BSPM_RUN) begin
      blank_cnt <= `BSPM_WAKE_BLANK_CYC;
    end else if (blank_cnt != 3'h0) begin
      blank_cnt <= blank_cnt - 3'h1;
    end
  end

  // Sleep request outputs, one per block per segment.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sif.sleep_req <= '0;
    end else if (blank_cnt != 3'h0 || (next_state == bspm_pkg::BSPM_RUN && state != bspm_pkg::BSPM_RUN)) begin
      sif.sleep_req <= '0;
    end else begin
      sif.sleep_req <= sleep_all ? {`BSPM_NB{1'b1}} : sleep_en;
    end
  end

  // Remembers a heavy-sleep entry until the PLL has relocked.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slept_heavy <= 1'b0;
    end else if (state == bspm_pkg::BSPM_RUN && next_state == bspm_pkg::BSPM_SLEEP) begin
      slept_heavy <= heavy;
    end else if (state == bspm_pkg::BSPM_RUN && lock_s) begin
      slept_heavy <= 1'b0;
    end
  end

  // Clock controls, registered from the next state.
  assign dom_on = next_state == bspm_pkg::BSPM_RUN || next_state == bspm_pkg::BSPM_PSEUDO ||
                  next_state == bspm_pkg::BSPM_WONLY;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dom_clk_en <= 1'b1;
      pll_en <= 1'b1;
      ring_osc_en <= 1'b0;
      espi_clk_en <= 1'b1;
      nonwake_irq_en <= 1'b1;
    end else begin
      dom_clk_en <= dom_on;
      pll_en <= next_state == bspm_pkg::BSPM_RUN || !(heavy || slept_heavy);
      ring_osc_en <= dom_on && !lock_s &&
                     (slept_heavy || (state == bspm_pkg::BSPM_RUN && next_state == bspm_pkg::BSPM_SLEEP && heavy));
      espi_clk_en <= dom_on || next_state == bspm_pkg::BSPM_ESPI;
      nonwake_irq_en <= next_state == bspm_pkg::BSPM_RUN;
    end
  end

  // Test clock toggles only while fully running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_clock_output <= 1'b0;
    end else if (next_state == bspm_pkg::BSPM_RUN) begin
      test_clock_output <= ~test_clock_output;
    end
  end

  // Control register; a write in the same cycle overrides the interrupt clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      heavy <= 1'b0;
      sleep_all <= 1'b0;
      early <= 1'b0;
    end else if (wr && paddr == `BSPM_OFF_CTRL) begin
      heavy <= pwdata[`BSPM_CTRL_HEAVY];
      sleep_all <= pwdata[`BSPM_CTRL_ALL];
      early <= pwdata[`BSPM_CTRL_EARLY];
    end else if (cpu_irq_taken) begin
      sleep_all <= 1'b0;
    end
  end

  // Per-block sleep enables and wake-only enables.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_en <= `BSPM_RST_SLEEP_EN;
      wo_en <= `BSPM_RST_WO_EN;
    end else if (wr && paddr == `BSPM_OFF_SLEEP_EN) begin
      sleep_en <= pwdata[`BSPM_NB-1:0];
    end else if (wr && paddr == `BSPM_OFF_WO_EN) begin
      wo_en <= pwdata[`BSPM_WO_W-1:0];
    end
  end

  // APB answer: read data and error captured in the setup cycle, no wait states.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        pslverr <= !(paddr == `BSPM_OFF_CTRL || paddr == `BSPM_OFF_STATUS || paddr == `BSPM_OFF_SLEEP_EN ||
                     paddr == `BSPM_OFF_WO_EN || paddr == `BSPM_OFF_CLK_REQ);
      end
      if (rd) begin
        prdata <= 32'h0000_0000;
        unique case (paddr)
          `BSPM_OFF_CTRL: begin
            prdata[`BSPM_CTRL_HEAVY] <= heavy;
            prdata[`BSPM_CTRL_ALL] <= sleep_all;
            prdata[`BSPM_CTRL_EARLY] <= early;
          end
          `BSPM_OFF_STATUS: begin
            prdata[`BSPM_ST_STATE+2:`BSPM_ST_STATE] <= state;
            prdata[`BSPM_ST_LOCK] <= lock_s;
            prdata[`BSPM_ST_RING] <= ring_osc_en;
          end
          `BSPM_OFF_SLEEP_EN: prdata[`BSPM_NB-1:0] <= sleep_en;
          `BSPM_OFF_WO_EN: prdata[`BSPM_WO_W-1:0] <= wo_en;
          `BSPM_OFF_CLK_REQ: prdata[`BSPM_NB-1:0] <= dem_s;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ---- rtl/bspm_map.svh ----
`ifndef BSPM_MAP_SVH
`define BSPM_MAP_SVH
// Contract
// - One sleep request per block, grouped per segment.
// - Blocks drive clock demand; manager watches for gating.
// - Demand falls synchronously, rises asynchronously on access.
// - Idle unrequested block gates its own clock.
// - Idle block sleeps at once on rising request.
// - Busy block finishes, drops demand within 1 ms.
// - Register access raises demand whatever the request.
// - Wake event blanks all sleep requests briefly.
// - Sleep needs all requested, no demand, sleep instruction.
// - Processor programs sleep state before sleep instruction.
// - Commanded by global bit or all per-block bits.
// - Simple blocks drop demand immediately on request.
// - Only enabled wake interrupts wake; others held off.
// - Light sleep gates domain, PLL stays locked.
// - Heavy sleep stops PLL; ring oscillator until relock.
// - Global sleep bit clears on any taken interrupt.
// - Debug access pseudo-wakes without touching sleep state.
// - Wake-only event clocks domain, requests stay, resleep.
// - Chip-select fall clocks only eSPI for cycle.
// - Test clock toggles running, stops when asleep.
// - Early-heavy bit 8 allows entry before PLL lock.

// Sizes.
`define BSPM_NSEG 2
`define BSPM_NBLK 4
`define BSPM_NB 8
`define BSPM_WO_W 16
`define BSPM_WO_ESPI_BIT 9

// Register offsets (byte addresses).
`define BSPM_OFF_CTRL 12'h000
`define BSPM_OFF_STATUS 12'h004
`define BSPM_OFF_SLEEP_EN 12'h030
`define BSPM_OFF_WO_EN 12'h040
`define BSPM_OFF_CLK_REQ 12'h050

// Control field positions.
`define BSPM_CTRL_HEAVY 0
`define BSPM_CTRL_ALL 3
`define BSPM_CTRL_EARLY 8

// Status field positions.
`define BSPM_ST_STATE 0
`define BSPM_ST_LOCK 4
`define BSPM_ST_RING 5

// Reset values.
`define BSPM_RST_SLEEP_EN 8'h00
`define BSPM_RST_WO_EN 16'h0000

// Timing counts.
`define BSPM_WAKE_BLANK_CYC 3'h2
`define BSPM_WO_SETTLE_CYC 3'h4
`define BSPM_CLK_PERIOD_PS 5000
`define BSPM_FINISH_LIMIT_NS 1000000
`define BSPM_FINISH_LIMIT_CYC ((`BSPM_FINISH_LIMIT_NS * 1000) / `BSPM_CLK_PERIOD_PS)

// Blocks that drop demand at once when asked to sleep.
`define BSPM_SIMPLE_MASK 8'h88
`endif

// ---- rtl/bspm_pkg.sv ----
package bspm_pkg;
  typedef enum logic [2:0] {
    BSPM_RUN,
    BSPM_SLEEP,
    BSPM_PSEUDO,
    BSPM_WONLY,
    BSPM_ESPI
  } bspm_state_t;

  typedef enum logic [1:0] {
    BSPM_BLK_ACTIVE,
    BSPM_BLK_DRAIN,
    BSPM_BLK_ASLEEP
  } bspm_blk_state_t;
endpackage

// ---- rtl/bspm_sleep_if.sv ----
`timescale 1ns/1ps
`include "bspm_map.svh"
interface bspm_sleep_if;
  // Per-block sleep requests, segment s block b at bit s*NBLK+b.
  logic [`BSPM_NB-1:0] sleep_req;
  // Per-block clock demands, same layout.
  logic [`BSPM_NB-1:0] clk_demand;

  modport pm (
    output sleep_req,
    input clk_demand
  );
  modport blk (
    input sleep_req,
    output clk_demand
  );
endinterface

// ---- rtl/bspm_block_end.sv ----
`timescale 1ns/1ps
`include "bspm_map.svh"
module bspm_block_end #(
  parameter int unsigned FINISH_LIMIT_CYC = `BSPM_FINISH_LIMIT_CYC
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Sleep handshake with the power manager.
  bspm_sleep_if.blk sif,
  // Per-block activity.
  input wire logic [`BSPM_NB-1:0] busy,
  input wire logic [`BSPM_NB-1:0] reg_access,
  // Per-block status.
  output logic [`BSPM_NB-1:0] blk_clk_en,
  output logic [`BSPM_NB-1:0] asleep
);

  localparam logic [`BSPM_NB-1:0] SIMPLE = `BSPM_SIMPLE_MASK;
  localparam logic [17:0] LIMIT = 18'(FINISH_LIMIT_CYC - 1);

  logic [`BSPM_NB-1:0] dem_q, req_d;

  // Demand rises at once on a register access, without any clock edge.
  assign sif.clk_demand = dem_q | reg_access;

  for (genvar i = 0; i < `BSPM_NB; i++) begin : g_blk
    bspm_pkg::bspm_blk_state_t st, next_st;
    logic [17:0] cnt;

    // Per-block sleep protocol.
    always_comb begin
      next_st = st;
      unique case (st)
        bspm_pkg::BSPM_BLK_ACTIVE: begin
          if (sif.sleep_req[i] && !req_d[i]) begin
            next_st = (!busy[i] || SIMPLE[i]) ? bspm_pkg::BSPM_BLK_ASLEEP : bspm_pkg::BSPM_BLK_DRAIN;
          end
        end
        bspm_pkg::BSPM_BLK_DRAIN: begin
          if (!sif.sleep_req[i]) begin
            next_st = bspm_pkg::BSPM_BLK_ACTIVE;
          end else if (!busy[i] || cnt == LIMIT) begin
            next_st = bspm_pkg::BSPM_BLK_ASLEEP;
          end
        end
        bspm_pkg::BSPM_BLK_ASLEEP: begin
          if (!sif.sleep_req[i]) begin
            next_st = bspm_pkg::BSPM_BLK_ACTIVE;
          end
        end
        default: next_st = bspm_pkg::BSPM_BLK_ACTIVE;
      endcase
    end

    // State, drain timer and synchronous demand.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st <= bspm_pkg::BSPM_BLK_ACTIVE;
        cnt <= 18'h00000;
        dem_q[i] <= 1'b0;
        req_d[i] <= 1'b0;
        blk_clk_en[i] <= 1'b0;
        asleep[i] <= 1'b0;
      end else begin
        st <= next_st;
        req_d[i] <= sif.sleep_req[i];
        cnt <= (next_st == bspm_pkg::BSPM_BLK_DRAIN) ? cnt + 18'h00001 : 18'h00000;
        dem_q[i] <= (next_st == bspm_pkg::BSPM_BLK_DRAIN) ||
                    (next_st == bspm_pkg::BSPM_BLK_ACTIVE && busy[i]);
        blk_clk_en[i] <= (next_st == bspm_pkg::BSPM_BLK_DRAIN) ||
                         (next_st == bspm_pkg::BSPM_BLK_ACTIVE && busy[i]) || reg_access[i];
        asleep[i] <= next_st == bspm_pkg::BSPM_BLK_ASLEEP;
      end
    end
  end

endmodule

// ---- bench/bspm_sleep_checker.sv ----
`timescale 1ns/1ps
module bspm_sleep_checker #(
  parameter int unsigned FINISH_LIMIT_CYC = 16
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Sleep link.
  input wire logic [7:0] sleep_req,
  input wire logic [7:0] clk_demand,
  // Block end pins.
  input wire logic [7:0] busy,
  input wire logic [7:0] reg_access,
  input wire logic [7:0] asleep,
  // Manager pins.
  input wire logic dom_clk_en,
  input wire logic test_clock_output,
  input wire logic cpu_sleep,
  input wire logic wake_irq,
  input wire logic dbg_access
);
  // Longest wait for a busy block, with margin for the request edge.
  localparam int LIM = FINISH_LIMIT_CYC + 4;

  // All checks run on the one clock and pause during reset.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Wake steps: requests blanked for a while, then all back.
  sequence s_blank;
    (sleep_req == 8'h00) [*2];
  endsequence
  sequence s_full;
    sleep_req == 8'hff;
  endsequence

  property p_access_demand;
    (clk_demand & reg_access) == reg_access;
  endproperty
  property p_asleep_quiet;
    (clk_demand & asleep & ~reg_access) == 8'h00;
  endproperty
  property p_simple_drop;
    $rose(sleep_req[7]) |=> asleep[7];
  endproperty
  property p_busy_finish;
    $rose(sleep_req[0]) && busy[0] |=> clk_demand[0] ##[1:LIM] asleep[0];
  endproperty
  property p_sleep_entry;
    $fell(dom_clk_en) |-> sleep_req == 8'hff && cpu_sleep;
  endproperty
  property p_frozen;
    !dom_clk_en |-> $stable(test_clock_output);
  endproperty
  property p_running;
    dom_clk_en && $past(presetn) && sleep_req == 8'h00 && $past(sleep_req) == 8'h00
      |-> test_clock_output != $past(test_clock_output);
  endproperty
  property p_debug;
    $rose(dbg_access) && !dom_clk_en && !wake_irq |-> ##[1:6] dom_clk_en && sleep_req == 8'hff;
  endproperty
  property p_wake;
    $rose(wake_irq) && !dom_clk_en |-> ##[1:2] s_blank ##[1:2] s_full;
  endproperty

  a_access_demand: assert property (p_access_demand)
    else $error("clock demand low during register access");
  a_asleep_quiet: assert property (p_asleep_quiet)
    else $error("sleeping block demands clock");
  a_simple_drop: assert property (p_simple_drop)
    else $error("simple block did not sleep at once");
  a_busy_finish: assert property (p_busy_finish)
    else $error("busy block did not hold demand then sleep");
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("domain gated without all requests and sleep instruction");
  a_frozen: assert property (p_frozen)
    else $error("test clock moved while asleep");
  a_running: assert property (p_running)
    else $error("test clock stopped while running");
  a_debug: assert property (p_debug)
    else $error("debug access did not restart clocks with requests kept");
  a_wake: assert property (p_wake)
    else $error("wake did not blank and restore requests");
endmodule

// ---- bench/test_block_sleep_power_manager.sv ----
`timescale 1ns/1ps
`include "bspm_map.svh"
module test_block_sleep_power_manager;
  localparam int unsigned FIN = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, t;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic cpu_sleep, cpu_irq_taken, wake_irq, pll_lock, dbg_access;
  logic dom_clk_en, pll_en, ring_osc_en, nonwake_irq_en, test_clock_output, espi_clk_en, cs_n;
  logic [15:0] wo;
  logic [7:0] busy, reg_access, asleep, sreq, dem, bce;
  int miscompares, tests_run;

  bspm_sleep_if u_bspm_sleep_if ();
  assign sreq = u_bspm_sleep_if.sleep_req;
  assign dem = u_bspm_sleep_if.clk_demand;

  bspm_power_manager u_bspm_power_manager (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sif(u_bspm_sleep_if), .cpu_sleep(cpu_sleep), .cpu_irq_taken(cpu_irq_taken), .wake_irq(wake_irq),
    .espi_irq(1'b0), .pll_lock(pll_lock), .dbg_access(dbg_access), .wake_only_event_group(wo),
    .espi_cs_n(cs_n), .dom_clk_en(dom_clk_en), .pll_en(pll_en), .ring_osc_en(ring_osc_en),
    .espi_clk_en(espi_clk_en), .nonwake_irq_en(nonwake_irq_en), .test_clock_output(test_clock_output));
  bspm_block_end #(.FINISH_LIMIT_CYC(FIN)) u_bspm_block_end (.pclk(pclk), .presetn(presetn),
    .sif(u_bspm_sleep_if), .busy(busy), .reg_access(reg_access), .blk_clk_en(bce), .asleep(asleep));
  bspm_sleep_checker #(.FINISH_LIMIT_CYC(FIN)) u_bspm_sleep_checker (.pclk(pclk), .presetn(presetn),
    .sleep_req(sreq), .clk_demand(dem), .busy(busy), .reg_access(reg_access), .asleep(asleep),
    .dom_clk_en(dom_clk_en), .test_clock_output(test_clock_output), .cpu_sleep(cpu_sleep),
    .wake_irq(wake_irq), .dbg_access(dbg_access));

  // Free-running 200 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Compares one value and counts the result.
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // A wait that ran out is a mismatch and ends the run.
  task limit(input int n);
    if (n >= 50) begin
      miscompares++;
      wrap_up();
    end
  endtask

  // One APB transfer: setup, then access until pready.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    limit(n);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("prdata", x, r);
  endtask

  // Waits at falling edges until the domain clock enable reaches v.
  task dom_wait(input logic v);
    int n;
    n = 0;
    @(negedge pclk);
    while (dom_clk_en !== v && n < 50) begin
      @(negedge pclk);
      n++;
    end
    limit(n);
  endtask

  task cyc(input int k);
    repeat (k) @(negedge pclk);
  endtask

  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, cpu_sleep, cpu_irq_taken, wake_irq, pll_lock, dbg_access} = '0;
    {paddr, pwdata, wo, busy, reg_access} = '0;
    cs_n = 1'b1;
    miscompares = 0;
    tests_run = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(`BSPM_OFF_CTRL, 32'h0);
    rd(`BSPM_OFF_SLEEP_EN, 32'h0);
    rd(`BSPM_OFF_WO_EN, 32'h0);
    apb(1'b1, 12'h020, 32'hffffffff);
    chk("pslverr", 32'h1, 32'(e));
    @(posedge pclk);
    busy <= 8'h01;
    pll_lock <= 1'b1;
    apb(1'b1, `BSPM_OFF_SLEEP_EN, 32'hff);
    cyc(2);
    chk("sleep_req", 32'hff, 32'(sreq));
    cyc(1);
    chk("asleep", 32'hfe, 32'(asleep));
    chk("blk_clk_en", 32'h01, 32'(bce));
    chk("clk_demand", 32'h01, 32'(dem));
    cyc(FIN + 4);
    chk("asleep", 32'hff, 32'(asleep));
    chk("blk_clk_en", 32'h00, 32'(bce));
    chk("clk_demand", 32'h00, 32'(dem));
    @(posedge pclk);
    busy <= 8'h00;
    reg_access <= 8'h04;
    cyc(3);
    chk("clk_demand", 32'h04, 32'(dem));
    chk("blk_clk_en", 32'h04, 32'(bce));
    rd(`BSPM_OFF_CLK_REQ, 32'h04);
    @(posedge pclk);
    reg_access <= 8'h00;
    cpu_sleep <= 1'b1;
    dom_wait(1'b0);
    chk("pll_en", 32'h1, 32'(pll_en));
    chk("nonwake_irq_en", 32'h0, 32'(nonwake_irq_en));
    t = test_clock_output;
    cyc(4);
    chk("test_clock_output", 32'(t), 32'(test_clock_output));
    rd(`BSPM_OFF_STATUS, 32'h11);
    @(posedge pclk);
    dbg_access <= 1'b1;
    dom_wait(1'b1);
    chk("sleep_req", 32'hff, 32'(sreq));
    rd(`BSPM_OFF_STATUS, 32'h12);
    @(posedge pclk);
    dbg_access <= 1'b0;
    dom_wait(1'b0);
    apb(1'b1, `BSPM_OFF_WO_EN, 32'h201);
    @(posedge pclk);
    wo <= 16'h0001;
    dom_wait(1'b1);
    chk("sleep_req", 32'hff, 32'(sreq));
    rd(`BSPM_OFF_STATUS, 32'h13);
    @(posedge pclk);
    wo <= 16'h0000;
    cyc(6);
    dom_wait(1'b0);
    @(posedge pclk);
    cs_n <= 1'b0;
    cyc(4);
    chk("espi_clk_en", 32'h1, 32'(espi_clk_en));
    chk("dom_clk_en", 32'h0, 32'(dom_clk_en));
    rd(`BSPM_OFF_STATUS, 32'h14);
    @(posedge pclk);
    cs_n <= 1'b1;
    cyc(4);
    chk("espi_clk_en", 32'h0, 32'(espi_clk_en));
    @(posedge pclk);
    wake_irq <= 1'b1;
    cpu_sleep <= 1'b0;
    dom_wait(1'b1);
    chk("sleep_req", 32'h00, 32'(sreq));
    chk("ring_osc_en", 32'h0, 32'(ring_osc_en));
    cyc(4);
    chk("sleep_req", 32'hff, 32'(sreq));
    rd(`BSPM_OFF_STATUS, 32'h10);
    @(posedge pclk);
    wake_irq <= 1'b0;
    apb(1'b1, `BSPM_OFF_SLEEP_EN, 32'h0);
    apb(1'b1, `BSPM_OFF_CTRL, 32'h8);
    cyc(2);
    chk("sleep_req", 32'hff, 32'(sreq));
    @(posedge pclk);
    cpu_irq_taken <= 1'b1;
    @(posedge pclk);
    cpu_irq_taken <= 1'b0;
    pll_lock <= 1'b0;
    rd(`BSPM_OFF_CTRL, 32'h0);
    apb(1'b1, `BSPM_OFF_CTRL, 32'h9);
    @(posedge pclk);
    cpu_sleep <= 1'b1;
    cyc(12);
    chk("dom_clk_en", 32'h1, 32'(dom_clk_en));
    apb(1'b1, `BSPM_OFF_CTRL, 32'h109);
    dom_wait(1'b0);
    chk("pll_en", 32'h0, 32'(pll_en));
    @(posedge pclk);
    wake_irq <= 1'b1;
    cpu_sleep <= 1'b0;
    dom_wait(1'b1);
    cyc(1);
    chk("ring_osc_en", 32'h1, 32'(ring_osc_en));
    @(posedge pclk);
    pll_lock <= 1'b1;
    wake_irq <= 1'b0;
    cyc(4);
    chk("ring_osc_en", 32'h0, 32'(ring_osc_en));
    wrap_up();
  end
endmodule
